// ===== include/pll_pkg.sv
`default_nettype none
package pll_pkg;

  // register indices on the local register port
  localparam logic [1:0] CTRL_IDX = 2'h0;
  localparam logic [1:0] BW_IDX = 2'h1;
  localparam logic [1:0] PROG_IDX = 2'h2;

  // field positions in the control register
  localparam int CTRL_IRQ_EN_BIT = 7;
  localparam int CTRL_FLAG_BIT = 6;
  localparam int CTRL_PWR_BIT = 5;
  localparam int CTRL_BCS_BIT = 4;
  // unused low nibble of the control register reads as ones
  localparam logic [3:0] CTRL_LOW_ONES = 4'hf;

  // field positions in the bandwidth register
  localparam int BW_AUTO_BIT = 7;
  localparam int BW_LOCK_BIT = 6;
  localparam int BW_TRACK_BIT = 5;

  // values after reset
  localparam logic PWR_RST = 1'b1;
  localparam logic [7:0] PROG_RST = 8'h00;

  // source edges to wait on each clock during a base clock switch
  localparam logic [1:0] SW_EDGES = 2'h3;

  // nominal range step of the vco, in hertz
  localparam logic [26:0] F_NOM_HZ = 27'd4915200;

  // lock detector comparator outputs
  typedef struct packed {
    logic track_in;
    logic untrack_out;
    logic lock_in;
    logic unlock_out;
  } lock_det_s;

  // programming register layout
  typedef struct packed {
    logic [3:0] mul;
    logic [3:0] range;
  } prog_s;

  // base clock selector states
  typedef enum logic {SEL_RUN, SEL_SWITCH} sel_state_e;

  // multiplier with zero taken as one
  function automatic logic [3:0] eff_mul(input logic [3:0] n);
    eff_mul = (n == 4'h0) ? 4'h1 : n;
  endfunction

endpackage
`default_nettype wire

// ===== logic/pll_clock_ctrl.sv
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pll_clock_ctrl
  import pll_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire lock_det_s det_in,
  input wire logic xtal_clk,
  input wire logic vco_clk,
  output logic [7:0] rd_data,
  output logic lock_irq,
  output logic filter_track,
  output logic pll_enable,
  output logic fb_div_out,
  output logic [3:0] vco_range,
  output logic [26:0] vco_center_hz,
  output logic base_clk_out
);

  ////////////////////////////////////////////////////////////////////
  // state
  ////////////////////////////////////////////////////////////////////

  // detector synchroniser stages
  lock_det_s det_s1_r;
  lock_det_s det_s2_r;
  // control register bits
  logic irq_en_r;
  logic flag_r;
  logic pwr_r;
  logic bcs_r;
  // bandwidth register bits
  logic auto_r;
  logic track_r;
  logic lock_r;
  // programming register
  prog_s prog_r;
  // sampled source clocks
  logic xtal_d_r;
  logic vco_d_r;
  // feedback divider count
  logic [3:0] fb_cnt_r;
  // selector state
  sel_state_e sel_state_r;
  logic sel_cur_r;
  logic [1:0] x_cnt_r;
  logic [1:0] v_cnt_r;

  ////////////////////////////////////////////////////////////////////
  // register port decode
  ////////////////////////////////////////////////////////////////////

  // write strobes per register, read strobe for the control register only
  wire logic wr_ctrl = wr_en && (addr == CTRL_IDX);
  wire logic wr_bw = wr_en && (addr == BW_IDX);
  wire logic wr_prog = wr_en && (addr == PROG_IDX);
  wire logic rd_ctrl = rd_en && (addr == CTRL_IDX);

  // written control fields
  wire logic pwr_w = wdata[CTRL_PWR_BIT];
  wire logic bcs_w = wdata[CTRL_BCS_BIT];
  // a write that flips power may not move the select too
  wire logic pwr_change = pwr_w != pwr_r;

  // range zero blocks the loop
  wire logic range_zero = (prog_r.range == 4'h0);

  ////////////////////////////////////////////////////////////////////
  // control register next values
  ////////////////////////////////////////////////////////////////////

  // power may not drop while the select bit requests the vco
  wire logic pwr_nxt = (wr_ctrl && !bcs_r) ? pwr_w : pwr_r;

  // select write taken only when power is unchanged
  wire logic bcs_cand = (wr_ctrl && !pwr_change) ? bcs_w : bcs_r;

  // select forced clear while power off or range zero
  wire logic bcs_nxt = bcs_cand && pwr_r && !range_zero;

  // interrupt enable exists only in automatic mode
  wire logic irq_en_nxt = auto_r && (wr_ctrl ? wdata[CTRL_IRQ_EN_BIT] : irq_en_r);

  ////////////////////////////////////////////////////////////////////
  // bandwidth and lock next values
  ////////////////////////////////////////////////////////////////////

  // automatic / manual mode bit
  wire logic auto_nxt = wr_bw ? wdata[BW_AUTO_BIT] : auto_r;

  // hysteresis on the synchronised track comparators
  wire logic track_auto = det_s2_r.track_in ? 1'b1 :
                          (det_s2_r.untrack_out ? 1'b0 : track_r);

  // manual writes land only when not automatic
  wire logic track_man = wr_bw ? wdata[BW_TRACK_BIT] : track_r;

  // detector owns the bit in automatic mode
  wire logic track_nxt = auto_r ? track_auto : track_man;

  // lock hysteresis, held clear in manual mode
  wire logic lock_hyst = det_s2_r.lock_in ? 1'b1 :
                         (det_s2_r.unlock_out ? 1'b0 : lock_r);
  wire logic lock_nxt = auto_r && lock_hyst;

  // any change of lock state in automatic mode
  wire logic lock_toggle = auto_r && (lock_nxt != lock_r);

  // flag: set wins over the read clear
  wire logic flag_nxt = auto_r && (lock_toggle || (flag_r && !rd_ctrl));

  // programming register frozen while the power bit is set
  wire logic [7:0] prog_nxt = (wr_prog && !pwr_r) ? wdata : prog_r;

  ////////////////////////////////////////////////////////////////////
  // read data
  ////////////////////////////////////////////////////////////////////

  // assembled register images
  wire logic [7:0] ctrl_img = {irq_en_r, flag_r, pwr_r, bcs_r, CTRL_LOW_ONES};
  // low bits of the bandwidth image read zero
  wire logic [7:0] bw_img = {auto_r, lock_r, track_r, 5'h00};

  // unmapped index reads zero; idle cycles read zero
  wire logic [7:0] rd_nxt = !rd_en ? 8'h00 :
                            (addr == CTRL_IDX) ? ctrl_img :
                            (addr == BW_IDX) ? bw_img :
                            (addr == PROG_IDX) ? prog_r : 8'h00;

  ////////////////////////////////////////////////////////////////////
  // vco feedback divider
  ////////////////////////////////////////////////////////////////////

  // rising edges of the sampled clocks
  wire logic x_edge = xtal_clk && !xtal_d_r;
  wire logic v_edge = vco_clk && !vco_d_r && pll_enable;

  // effective multiplier
  wire logic [3:0] mul_eff = eff_mul(prog_r.mul);

  // divide by n: wrap after n vco edges
  wire logic fb_wrap = (fb_cnt_r >= mul_eff - 4'h1);
  wire logic [3:0] fb_cnt_nxt = !v_edge ? fb_cnt_r :
                                (fb_wrap ? 4'h0 : fb_cnt_r + 4'h1);

  // centre of range as l times the nominal step
  wire logic [26:0] center_nxt = 27'(prog_r.range) * F_NOM_HZ;

  ////////////////////////////////////////////////////////////////////
  // base clock selector
  ////////////////////////////////////////////////////////////////////

  // requested source: vco when select set
  wire logic sel_req = bcs_r;

  // edge counts saturate at the switch length
  wire logic x_done = (x_cnt_r == SW_EDGES);
  wire logic v_done = (v_cnt_r == SW_EDGES) || !pll_enable;
  wire logic [1:0] x_cnt_nxt = (x_edge && !x_done) ? x_cnt_r + 2'h1 : x_cnt_r;
  // vco count saturates on its own bound, not on the loop-off override
  wire logic [1:0] v_cnt_nxt = (v_edge && !(v_cnt_r == SW_EDGES)) ?
                               v_cnt_r + 2'h1 : v_cnt_r;

  // edge of the source now in use
  wire logic src_edge = sel_cur_r ? v_edge : x_edge;

  // switch ends when the crystal has given its edges and the vco its edges or the loop is off
  wire logic sw_end = (sel_state_r == SEL_SWITCH) && x_done && v_done;

  // next selector state
  sel_state_e sel_state_nxt;
  always_comb
  begin
    // hold the state unless a branch moves it
    sel_state_nxt = sel_state_r;
    case (sel_state_r)
      // running: a new request starts a switch
      SEL_RUN:
      begin
        if (sel_req != sel_cur_r)
        begin
          sel_state_nxt = SEL_SWITCH;
        end
      end
      // switching: output held until both counts done
      SEL_SWITCH:
      begin
        if (x_done && v_done)
        begin
          sel_state_nxt = SEL_RUN;
        end
      end
      default:
      begin
        sel_state_nxt = SEL_RUN;
      end
    endcase
  end

  // toggle only while running, so output is static in a switch
  wire logic base_nxt = (sel_state_r == SEL_RUN && sel_req == sel_cur_r && src_edge) ?
                        !base_clk_out : base_clk_out;

  ////////////////////////////////////////////////////////////////////
  // detector synchroniser
  ////////////////////////////////////////////////////////////////////

  // two flops before any use of the comparators
  always_ff @(posedge clock or negedge rstn)
  begin
    // both stages cleared on reset
    if (!rstn)
    begin
      det_s1_r <= '0;
      det_s2_r <= '0;
    end
    // comparator levels shift one stage per edge
    else
    begin
      det_s1_r <= det_in;
      // the first stage feeds only the second
      det_s2_r <= det_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // software registers
  ////////////////////////////////////////////////////////////////////

  // control, bandwidth and programming bits
  always_ff @(posedge clock or negedge rstn)
  begin
    // reset values, power on by default
    if (!rstn)
    begin
      irq_en_r <= 1'b0;
      flag_r <= 1'b0;
      pwr_r <= PWR_RST;
      bcs_r <= 1'b0;
      auto_r <= 1'b0;
      track_r <= 1'b0;
      lock_r <= 1'b0;
      prog_r <= PROG_RST;
    end
    // every bit takes its next value each edge
    else
    begin
      irq_en_r <= irq_en_nxt;
      flag_r <= flag_nxt;
      pwr_r <= pwr_nxt;
      bcs_r <= bcs_nxt;
      auto_r <= auto_nxt;
      // indications follow the synchronised detector in automatic mode only
      track_r <= track_nxt;
      lock_r <= lock_nxt;
      prog_r <= prog_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs to the loop and the bus
  ////////////////////////////////////////////////////////////////////

  // registered outputs
  always_ff @(posedge clock or negedge rstn)
  begin
    // all outputs low in reset
    if (!rstn)
    begin
      rd_data <= 8'h00;
      lock_irq <= 1'b0;
      filter_track <= 1'b0;
      pll_enable <= 1'b0;
      vco_range <= 4'h0;
      vco_center_hz <= 27'h0;
    end
    // outputs copy settled state one edge later
    else
    begin
      rd_data <= rd_nxt;
      // interrupt only from an enabled flag in automatic mode
      lock_irq <= flag_r && irq_en_r && auto_r;
      filter_track <= track_r;
      pll_enable <= pwr_r && !range_zero;
      vco_range <= prog_r.range;
      vco_center_hz <= center_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // divider and selector flops
  ////////////////////////////////////////////////////////////////////

  // source sampling and feedback divider
  always_ff @(posedge clock or negedge rstn)
  begin
    // samples and count start from zero
    if (!rstn)
    begin
      xtal_d_r <= 1'b0;
      vco_d_r <= 1'b0;
      fb_cnt_r <= 4'h0;
      fb_div_out <= 1'b0;
    end
    // one sample of each source per edge
    else
    begin
      xtal_d_r <= xtal_clk;
      vco_d_r <= vco_clk;
      fb_cnt_r <= fb_cnt_nxt;
      // pulse marks the first vco edge of each divide cycle
      fb_div_out <= v_edge ? (fb_cnt_r == 4'h0) : fb_div_out;
    end
  end

  // transition control and divide by two
  always_ff @(posedge clock or negedge rstn)
  begin
    // crystal is the source out of reset
    if (!rstn)
    begin
      sel_state_r <= SEL_RUN;
      sel_cur_r <= 1'b0;
      x_cnt_r <= 2'h0;
      v_cnt_r <= 2'h0;
      base_clk_out <= 1'b0;
    end
    // selector advances every edge
    else
    begin
      sel_state_r <= sel_state_nxt;
      // new source adopted at the end of a switch
      sel_cur_r <= sw_end ? sel_req : sel_cur_r;
      // counts cleared while running
      x_cnt_r <= (sel_state_r == SEL_SWITCH) ? x_cnt_nxt : 2'h0;
      v_cnt_r <= (sel_state_r == SEL_SWITCH) ? v_cnt_nxt : 2'h0;
      // divide by two of the selected source
      base_clk_out <= base_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== bench/pll_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pll_ctrl_assertions
  import pll_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [1:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic xtal_clk,
  input wire logic [7:0] rd_data,
  input wire logic lock_irq,
  input wire logic pll_enable,
  input wire logic [3:0] vco_range,
  input wire logic [26:0] vco_center_hz,
  input wire logic base_clk_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // cycles since the crystal clock was last seen rising, saturating
  logic [3:0] x_age_r;
  logic x_prev_r;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      x_age_r <= 4'hf;
      x_prev_r <= 1'b0;
    end
    else
    begin
      x_prev_r <= xtal_clk;
      x_age_r <= (xtal_clk && !x_prev_r) ? 4'h0 : ((x_age_r == 4'hf) ? x_age_r : x_age_r + 4'h1);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // register read strobes
  sequence s_ctrl_rd;
    rd_en && addr == CTRL_IDX;
  endsequence
  sequence s_bw_rd;
    rd_en && addr == BW_IDX;
  endsequence
  property p_center;
    vco_center_hz == 27'(vco_range) * F_NOM_HZ;
  endproperty
  property p_enable;
    pll_enable |-> vco_range != 4'h0;
  endproperty
  property p_bcs_pwr;
    s_ctrl_rd ##1 rd_data[CTRL_BCS_BIT] |-> rd_data[CTRL_PWR_BIT] && pll_enable;
  endproperty
  property p_pwr_off;
    s_ctrl_rd ##1 !rd_data[CTRL_PWR_BIT] |-> !pll_enable;
  endproperty
  property p_manual_lock;
    s_bw_rd ##1 !rd_data[BW_AUTO_BIT] |-> !rd_data[BW_LOCK_BIT];
  endproperty
  property p_manual_irq;
    s_bw_rd ##1 !rd_data[BW_AUTO_BIT] |-> !lock_irq;
  endproperty
  property p_irq_hold;
    lock_irq && !rd_en && !$past(rd_en) && !wr_en && !$past(wr_en) |=> lock_irq;
  endproperty
  property p_xtal_src;
    $changed(base_clk_out) && !pll_enable |-> x_age_r <= 4'h5;
  endproperty
  a_center: assert property (p_center) else $error("center frequency mismatch");
  a_enable: assert property (p_enable) else $error("loop on with zero range");
  a_bcs_pwr: assert property (p_bcs_pwr) else $error("select without power");
  a_pwr_off: assert property (p_pwr_off) else $error("loop on while off");
  a_manual_lock: assert property (p_manual_lock) else $error("lock in manual");
  a_manual_irq: assert property (p_manual_irq) else $error("irq in manual");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped unread");
  a_xtal_src: assert property (p_xtal_src) else $error("base clock off crystal");
endmodule
`default_nettype wire

// ===== bench/sys_clk_env.sv
`timescale 1ns/1ps
`default_nettype none
// crystal and vco sources plus the base clock consumer
module sys_clk_env (
  output logic xtal_clk,
  output logic vco_clk,
  input wire logic base_clk_out,
  output int base_rises
);
  initial
  begin
    xtal_clk = 1'b0;
    forever #500 xtal_clk = ~xtal_clk;
  end
  initial
  begin
    vco_clk = 1'b0;
    // offset keeps vco edges clear of the sampling edge
    #20;
    forever #350 vco_clk = ~vco_clk;
  end
  // consumer counts base clock periods
  initial base_rises = 0;
  always @(posedge base_clk_out) base_rises++;
endmodule
`default_nettype wire

// ===== bench/tb_pll_mode_and_base_clock_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pll_mode_and_base_clock_select
  import pll_pkg::*;
;
  typedef struct packed {logic [1:0] a; logic [7:0] d; logic w; logic [7:0] e;} row_s;
  logic clock, rstn, wr_en, rd_en, lock_irq, filter_track, pll_enable, fb_div_out;
  logic xtal_clk, vco_clk, base_clk_out;
  logic [1:0] addr;
  logic [7:0] wdata, rd_data, v;
  logic [3:0] vco_range;
  logic [26:0] vco_center_hz;
  lock_det_s det_in;
  int error_cnt, samples_checked, base_rises, fb_rises, b, f;
  row_s rows [11] = '{'{CTRL_IDX, 8'h00, 1'b0, 8'h2f}, '{BW_IDX, 8'h00, 1'b0, 8'h00},
    '{PROG_IDX, 8'h00, 1'b0, 8'h00}, '{2'h3, 8'h5a, 1'b1, 8'h00},
    '{CTRL_IDX, 8'h30, 1'b1, 8'h2f},
    '{PROG_IDX, 8'h87, 1'b1, 8'h00}, '{CTRL_IDX, 8'h10, 1'b1, 8'h0f},
    '{PROG_IDX, 8'h87, 1'b1, 8'h87}, '{CTRL_IDX, 8'h10, 1'b1, 8'h0f},
    '{CTRL_IDX, 8'h20, 1'b1, 8'h2f}, '{CTRL_IDX, 8'h30, 1'b1, 8'h3f}};
  pll_clock_ctrl u_dut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .det_in(det_in), .xtal_clk(xtal_clk), .vco_clk(vco_clk),
    .rd_data(rd_data), .lock_irq(lock_irq), .filter_track(filter_track),
    .pll_enable(pll_enable), .fb_div_out(fb_div_out), .vco_range(vco_range),
    .vco_center_hz(vco_center_hz), .base_clk_out(base_clk_out));
  sys_clk_env u_env (.xtal_clk(xtal_clk), .vco_clk(vco_clk), .base_clk_out(base_clk_out),
    .base_rises(base_rises));
  always @(posedge fb_div_out) fb_rises++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [26:0] s, input logic [26:0] e, input string n);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // one-cycle write, leaves time just after the edge
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask
  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [1:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // base clock and feedback periods seen over a window
  task automatic meas(input int n);
    b = base_rises;
    f = fb_rises;
    idle(n);
    b = base_rises - b;
    f = fb_rises - f;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    complete_run();
  end
  initial
  begin
    {rstn, wr_en, rd_en, addr, wdata, det_in, fb_rises, error_cnt, samples_checked} = '0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    idle(1);
    chk(pll_enable, 1'b0, "enable_rst");
    foreach (rows[i])
    begin
      if (rows[i].w) wr(rows[i].a, rows[i].d); // loop turned on with track clear
      rd(rows[i].a);
      chk(v, rows[i].e, "row");
    end
    chk({pll_enable, vco_range}, 5'h17, "loop_on");
    wr(CTRL_IDX, 8'h20);
    chk(vco_center_hz, 27'd7 * F_NOM_HZ, "center");
    idle(20); // acquisition wait after power on
    wr(BW_IDX, 8'h20);
    idle(3);
    chk(filter_track, 1'b1, "manual_track");
    wr(BW_IDX, 8'h00);
    det_in.lock_in <= 1'b1;
    det_in.track_in <= 1'b1;
    idle(6);
    chk(filter_track, 1'b0, "manual_acq");
    wr(CTRL_IDX, 8'ha0);
    rd(BW_IDX);
    chk(v, 8'h00, "manual_bw");
    rd(CTRL_IDX);
    chk(v, 8'h2f, "manual_ctrl");
    wr(BW_IDX, 8'h80);
    wr(CTRL_IDX, 8'ha0);
    idle(6);
    chk({filter_track, lock_irq}, 2'b11, "auto_in");
    rd(CTRL_IDX);
    chk(v, 8'hef, "auto_flag");
    wr(BW_IDX, 8'h80);
    rd(BW_IDX);
    chk(v, 8'he0, "auto_bw");
    det_in <= '0;
    idle(6);
    rd(BW_IDX);
    chk({v, lock_irq}, 9'h1c0, "hyst_hold");
    det_in.unlock_out <= 1'b1;
    det_in.untrack_out <= 1'b1;
    idle(6);
    rd(BW_IDX);
    chk({v, filter_track, lock_irq}, 10'h201, "auto_out");
    rd(CTRL_IDX);
    chk(v, 8'hef, "drop_flag");
    wr(CTRL_IDX, 8'h20);
    wr(BW_IDX, 8'h20); // manual mode before the vco is chosen; write lands while still automatic, so track stays clear
    idle(60); // lock wait with tracking clear
    meas(200);
    chk(27'(b >= 9 && b <= 11), 27'd1, "xtal_div");
    wr(CTRL_IDX, 8'h30);
    idle(60);
    meas(560);
    chk(27'(b >= 39 && b <= 41), 27'd1, "vco_div");
    chk(27'(f >= 9 && f <= 11), 27'd1, "fb_div");
    wr(CTRL_IDX, 8'h00);
    rd(CTRL_IDX);
    chk(v, 8'h3f, "pwr_held");
    wr(CTRL_IDX, 8'h20);
    idle(60);
    wr(CTRL_IDX, 8'h00);
    wr(PROG_IDX, 8'h07);
    chk(pll_enable, 1'b0, "pwr_off");
    wr(BW_IDX, 8'h00); // track cleared before the loop is turned on
    wr(CTRL_IDX, 8'h20);
    idle(30);
    chk({pll_enable, fb_div_out}, 2'b11, "mul_zero");
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    idle(1);
    rd(CTRL_IDX);
    chk(v, 8'h2f, "ctrl_rst");
    rd(PROG_IDX);
    chk({v, pll_enable}, 9'h000, "prog_rst");
    complete_run();
  end
endmodule
bind pll_clock_ctrl pll_ctrl_assertions u_chk (.clock(clock), .rstn(rstn), .addr(addr),
  .wr_en(wr_en), .rd_en(rd_en), .xtal_clk(xtal_clk), .rd_data(rd_data), .lock_irq(lock_irq),
  .pll_enable(pll_enable), .vco_range(vco_range), .vco_center_hz(vco_center_hz),
  .base_clk_out(base_clk_out));
`default_nettype wire
